/* File: rtl/fifo_mem_if.sv */
// Port bundle between the transmit FIFO control and its storage
`timescale 1ns/10ps
interface fifo_mem_if #(parameter int W = 10, parameter int AW = 11) ();
    logic we;
    logic [AW-1:0] waddr;
    logic [W-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [W-1:0] rdata;
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
    modport user (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

/* File: rtl/mac_framing_and_tx_pcs.sv */
// Ethernet MAC framing, deferral, back-off and 100 Mb/s transmit coding path
// Functional notes
// - Frame opens with seven 0x55 preamble bytes then the 0xD5 start byte.
// - Length/type up to 05DC is a length; 05DD and above is a type.
// - Payload under 46 bytes is zero padded unless that frame disables padding.
// - A 32-bit CRC over the frame closes every frame.
// - First two of sixteen preamble nibbles are replaced by J and K.
// - T then R follow the last FCS nibble.
// - Receive without J/K start drops the frame until the next start.
// - Receive end missing T/R flags a CRC error.
// - Carrier during the first 64-bit gap restarts the gap count.
// - After the 32-bit second gap, transmit regardless of carrier.
// - After jam, wait r slots, r random below 2^min(n,10).
// - Coder samples each transmit nibble per nibble period, maps to 5 bits.
// - Idle code-groups go out whenever nothing is sent.
// - Every code-group passes a scrambler seeded from a 10-bit seed.
// - Five-bit groups are serialized to a bit stream.
// - NRZ to NRZI unless the conversion enable is cleared.
// - The line bit stream is encoded to three-level MLT3.
// - Transmit FIFO of 2 KB holds up to 2048 bytes, counted from the start of the frame being sent.
`timescale 1ns/10ps
module mac_framing_and_tx_pcs #(
    parameter int FIFO_DEPTH = 2048
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_last,
    input wire logic wr_no_pad,
    input wire logic crs,
    input wire logic col,
    input wire logic nrzi_convert_enable,
    input wire logic [4:0] rx_group,
    input wire logic rx_group_valid,
    output logic mlt3_pos,
    output logic mlt3_neg,
    output logic tx_active,
    output logic frame_is_type,
    output logic [3:0] rx_nibble,
    output logic rx_nibble_valid,
    output logic rx_frame_end,
    output logic rx_crc_error,
    output logic rx_frame_discard
);
    import mac_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);

    typedef struct packed {
        logic crs1, crs2, col1, col2, nz1, nz2;
        logic [2:0] div;
        mac_state_t st;
        logic [AW:0] wptr, rptr, fstart, frames;
        logic [7:0] cnt;
        logic [11:0] bytes;
        logic hi, last, nopad, tx_en, is_type;
        logic [7:0] cur;
        logic [3:0] txd;
        logic [31:0] crc;
        logic [4:0] attempts;
        logic [9:0] slots;
        logic [15:0] lfsr, lentype;
        pcs_state_t pcs;
        logic [4:0] cg, sh;
        logic [10:0] scr;
        logic nrzi, line_prev, pos, neg;
        logic [1:0] mlt;
        rx_state_t rx;
        logic [3:0] rx_nib;
        logic rx_nv, rx_end, rx_err, rx_drop;
    } state_t;

    state_t r, next_r;
    logic nib, sbit, line, push;
    logic [AW:0] used;
    logic [9:0] rd;
    logic [31:0] fcs;
    logic [4:0] dn;

    fifo_mem_if #(.W(10), .AW(AW)) mif ();

    tx_fifo_mem #(.W(10), .AW(AW)) u_mem (
        .clk(clk),
        .port(mif.mem)
    );

    // FIFO space counts from the frame start, so a retry can rewind
    assign used = r.wptr - r.fstart;
    assign wr_ready = !used[AW];
    assign push = wr_valid && wr_ready;
    assign mif.we = push;
    assign mif.waddr = r.wptr[AW-1:0];
    assign mif.wdata = {wr_no_pad, wr_last, wr_data};
    assign mif.raddr = r.rptr[AW-1:0];
    assign rd = mif.rdata;
    assign nib = (r.div == DIV_LAST);
    assign fcs = ~r.crc;

    // Next state of the whole block
    always_comb begin
        next_r = r;
        dn = dec5b4b(rx_group);
        sbit = 1'b0;
        line = 1'b0;
        // Carrier, collision and NRZI enable pins cross two flops before use
        next_r.crs1 = crs;
        next_r.crs2 = r.crs1;
        next_r.col1 = col;
        next_r.col2 = r.col1;
        next_r.nz1 = nrzi_convert_enable;
        next_r.nz2 = r.nz1;
        next_r.div = nib ? 3'h0 : r.div + 3'h1;
        next_r.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
        next_r.rx_nv = 1'b0;
        next_r.rx_end = 1'b0;
        next_r.rx_err = 1'b0;
        next_r.rx_drop = 1'b0;
        if (push) begin
            next_r.wptr = r.wptr + 1'b1;
        end
        if (push && wr_last) begin
            next_r.frames = r.frames + 1'b1;
        end

        // Transmit MAC
        unique case (r.st)
            M_IDLE: begin
                if (r.frames != '0) begin
                    next_r.st = M_GAP1;
                    next_r.cnt = 8'h00;
                end
            end
            M_GAP1: begin
                if (r.crs2) begin
                    next_r.cnt = 8'h00;
                end else if (r.cnt == 8'(FIRST_GAP_INTERVAL_CYC - 1)) begin
                    next_r.st = M_GAP2;
                    next_r.cnt = 8'h00;
                end else begin
                    next_r.cnt = r.cnt + 8'h01;
                end
            end
            M_GAP2: begin
                // Carrier no longer defers once here
                if (r.cnt != 8'(SECOND_GAP_INTERVAL_CYC - 1)) begin
                    next_r.cnt = r.cnt + 8'h01;
                end else if (nib) begin
                    next_r.st = M_PRE;
                    next_r.tx_en = 1'b1;
                    next_r.txd = PRE_NIB;
                    next_r.cnt = 8'h00;
                    next_r.crc = CRC_INIT;
                    next_r.bytes = 12'h000;
                    next_r.rptr = r.fstart;
                    next_r.lentype = 16'h0000;
                    next_r.is_type = 1'b0;
                end
            end
            M_PRE: begin
                if (nib && r.cnt != PRE_NIBS - 8'h01) begin
                    next_r.cnt = r.cnt + 8'h01;
                    next_r.txd = (r.cnt == PRE_NIBS - 8'h02) ? SFD_HI : PRE_NIB;
                end else if (nib) begin
                    next_r.st = M_DATA;
                    next_r.cur = rd[7:0];
                    next_r.last = rd[8];
                    next_r.nopad = rd[9];
                    next_r.txd = rd[3:0];
                    next_r.hi = 1'b0;
                end
            end
            M_DATA: begin
                if (nib && !r.hi) begin
                    next_r.txd = r.cur[7:4];
                    next_r.hi = 1'b1;
                    next_r.crc = crc_byte(r.crc, r.cur);
                    next_r.bytes = r.bytes + 12'h001;
                    next_r.rptr = r.rptr + 1'b1;
                    if (r.bytes == LT_HI_IDX) begin
                        next_r.lentype[15:8] = r.cur;
                    end
                    if (r.bytes == LT_LO_IDX) begin
                        next_r.lentype[7:0] = r.cur;
                        next_r.is_type = {r.lentype[15:8], r.cur} > LEN_MAX;
                    end
                    if (r.last) begin
                        next_r.cnt = 8'h00;
                        next_r.st = (r.bytes + 12'h001 < MIN_BYTES && !r.nopad) ? M_PAD : M_FCS;
                    end
                end else if (nib) begin
                    next_r.cur = rd[7:0];
                    next_r.last = rd[8];
                    next_r.txd = rd[3:0];
                    next_r.hi = 1'b0;
                end
            end
            M_PAD: begin
                // Zero bytes until the frame reaches its least length
                if (nib) begin
                    next_r.txd = 4'h0;
                    next_r.hi = !r.hi;
                end
                if (nib && !r.hi) begin
                    next_r.crc = crc_byte(r.crc, 8'h00);
                    next_r.bytes = r.bytes + 12'h001;
                    if (r.bytes + 12'h001 == MIN_BYTES) begin
                        next_r.st = M_FCS;
                    end
                end
            end
            M_FCS: begin
                if (nib && r.cnt != FCS_NIBS) begin
                    next_r.txd = 4'(fcs >> {r.cnt[2:0], 2'b00});
                    next_r.cnt = r.cnt + 8'h01;
                end else if (nib) begin
                    next_r.tx_en = 1'b0;
                    next_r.fstart = r.rptr;
                    next_r.frames = next_r.frames - 1'b1;
                    next_r.attempts = 5'h00;
                    // Back to idle, so an empty FIFO never starts a frame
                    next_r.st = M_IDLE;
                    next_r.cnt = 8'h00;
                end
            end
            M_JAM: begin
                if (nib && r.cnt != JAM_NIBS) begin
                    next_r.txd = PRE_NIB;
                    next_r.cnt = r.cnt + 8'h01;
                end else if (nib) begin
                    next_r.tx_en = 1'b0;
                    next_r.attempts = (r.attempts == 5'h1F) ? r.attempts : r.attempts + 5'h01;
                    next_r.slots = r.lfsr[9:0] & boff_mask(next_r.attempts);
                    next_r.st = M_BOFF;
                    next_r.cnt = 8'h00;
                end
            end
            M_BOFF: begin
                if (r.slots == 10'h000) begin
                    next_r.st = M_GAP1;
                    next_r.cnt = 8'h00;
                end else if (r.cnt == 8'(SLOT_CYC - 1)) begin
                    next_r.cnt = 8'h00;
                    next_r.slots = r.slots - 10'h001;
                end else begin
                    next_r.cnt = r.cnt + 8'h01;
                end
            end
            default: begin
                next_r.st = M_IDLE;
            end
        endcase
        // Collision while sending cuts into jam
        if (r.col2 && (r.st == M_PRE || r.st == M_DATA || r.st == M_PAD || r.st == M_FCS)) begin
            next_r.st = M_JAM;
            next_r.cnt = 8'h00;
        end

        // Coder takes the nibble of the last period on each nibble enable
        if (nib) begin
            unique case (r.pcs)
                P_IDLE: begin
                    next_r.cg = r.tx_en ? CG_J : CG_I;
                    next_r.pcs = r.tx_en ? P_K : P_IDLE;
                end
                P_K: begin
                    next_r.cg = CG_K;
                    next_r.pcs = P_DATA;
                end
                P_DATA: begin
                    next_r.cg = r.tx_en ? enc4b5b(r.txd) : CG_T;
                    next_r.pcs = r.tx_en ? P_DATA : P_R;
                end
                P_R: begin
                    next_r.cg = CG_R;
                    next_r.pcs = P_IDLE;
                end
            endcase
            next_r.sh = next_r.cg;
        end else begin
            next_r.sh = {r.sh[3:0], 1'b0};
        end
        // Bit-wise scrambling covers idle and delimiters alike
        next_r.scr = {r.scr[9:0], r.scr[10] ^ r.scr[8]};
        sbit = r.sh[4] ^ r.scr[10] ^ r.scr[8];
        next_r.nrzi = r.nrzi ^ sbit;
        line = r.nz2 ? next_r.nrzi : sbit;
        next_r.line_prev = line;
        if (line != r.line_prev) begin
            next_r.mlt = r.mlt + 2'h1;
        end
        next_r.pos = (next_r.mlt == 2'h1);
        next_r.neg = (next_r.mlt == 2'h3);

        // Receive delimiter checks and 5B to 4B decoding on received code-groups
        if (rx_group_valid) begin
            unique case (r.rx)
                X_IDLE: begin
                    if (rx_group == CG_J) begin
                        next_r.rx = X_K;
                    end else if (rx_group != CG_I) begin
                        next_r.rx = X_DROP;
                        next_r.rx_drop = 1'b1;
                    end
                end
                X_K: begin
                    next_r.rx = (rx_group == CG_K) ? X_DATA : X_DROP;
                    next_r.rx_drop = (rx_group != CG_K);
                end
                X_DATA: begin
                    if (dn[4]) begin
                        next_r.rx_nib = dn[3:0];
                        next_r.rx_nv = 1'b1;
                    end else if (rx_group == CG_T) begin
                        next_r.rx = X_T;
                    end else begin
                        next_r.rx_err = 1'b1;
                        next_r.rx = (rx_group == CG_I) ? X_IDLE : X_DROP;
                    end
                end
                X_T: begin
                    next_r.rx_end = (rx_group == CG_R);
                    next_r.rx_err = (rx_group != CG_R);
                    next_r.rx = (rx_group == CG_R || rx_group == CG_I) ? X_IDLE : X_DROP;
                end
                X_DROP: begin
                    if (rx_group == CG_I) begin
                        next_r.rx = X_IDLE;
                    end
                end
                default: begin
                    next_r.rx = X_IDLE;
                end
            endcase
        end
    end

    // State register; seeds load at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.scr <= {1'b1, SCR_SEED};
            r.lfsr <= LFSR_SEED;
            r.crc <= CRC_INIT;
            r.cg <= CG_I;
        end else begin
            r <= next_r;
        end
    end

    assign mlt3_pos = r.pos;
    assign mlt3_neg = r.neg;
    assign tx_active = r.tx_en;
    assign frame_is_type = r.is_type;
    assign rx_nibble = r.rx_nib;
    assign rx_nibble_valid = r.rx_nv;
    assign rx_frame_end = r.rx_end;
    assign rx_crc_error = r.rx_err;
    assign rx_frame_discard = r.rx_drop;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence jk_s;
        r.cg == CG_J ##5 r.cg == CG_K;
    endsequence

    sfd_nibble_a: assert property ((r.st == M_PRE && r.cnt == 8'h0E && nib) |=> r.txd == SFD_HI) else $error("start byte nibble wrong");
    type_class_a: assert property ((r.st == M_FCS) |-> r.is_type == (r.lentype > LEN_MAX)) else $error("length/type class wrong");
    pad_length_a: assert property ((r.st == M_FCS && !r.nopad) |-> r.bytes >= MIN_BYTES) else $error("frame left short");
    start_delim_a: assert property ((nib && r.tx_en && r.pcs == P_IDLE) |=> jk_s) else $error("J/K missing");
    end_delim_a: assert property ((nib && !r.tx_en && r.pcs == P_DATA) |=> r.cg == CG_T ##5 r.cg == CG_R) else $error("T/R missing");
    rx_discard_a: assert property ((rx_group_valid && r.rx == X_IDLE && rx_group != CG_I && rx_group != CG_J) |=> rx_frame_discard && r.rx == X_DROP) else $error("frame not dropped");
    rx_crc_flag_a: assert property ((rx_group_valid && r.rx == X_DATA && rx_group == CG_I) |=> rx_crc_error) else $error("missing end not flagged");
    gap_restart_a: assert property ((r.st == M_GAP1 && r.crs2) |=> r.cnt == 8'h00 && r.st == M_GAP1) else $error("gap not restarted");
    gap_commit_a: assert property ((r.st == M_GAP2 && r.cnt == 8'(SECOND_GAP_INTERVAL_CYC - 1) && nib) |=> r.st == M_PRE && tx_active) else $error("no start after gap");
    backoff_range_a: assert property ((r.st == M_JAM && next_r.st == M_BOFF) |=> (r.slots & ~boff_mask(r.attempts)) == 10'h000) else $error("back-off out of range");
    idle_fill_a: assert property ((nib && r.pcs == P_IDLE && !r.tx_en) |=> r.cg == CG_I) else $error("idle not sent");
endmodule

/* File: rtl/mac_pkg.sv */
// Shared constants, types and coding functions of the MAC and transmit coder
package mac_pkg;
    // Timing: clk period and bit time at 100 Mb/s, both in ns
    localparam int CLK_NS = 25;
    localparam int BIT_NS = 10;
    localparam int FIRST_GAP_INTERVAL_BITS = 64;
    localparam int SECOND_GAP_INTERVAL_BITS = 32;
    localparam int SLOT_BITS = 512;
    // Least times, so counts round up
    localparam int FIRST_GAP_INTERVAL_CYC = (FIRST_GAP_INTERVAL_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SECOND_GAP_INTERVAL_CYC = (SECOND_GAP_INTERVAL_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOT_CYC = (SLOT_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] DIV_LAST = 3'h4;
    localparam logic [7:0] PRE_NIBS = 8'h10;
    localparam logic [7:0] FCS_NIBS = 8'h08;
    localparam logic [7:0] JAM_NIBS = 8'h08;
    localparam logic [11:0] MIN_BYTES = 12'h03C;
    localparam logic [11:0] LT_HI_IDX = 12'h00C;
    localparam logic [11:0] LT_LO_IDX = 12'h00D;
    localparam logic [4:0] BOFF_LIMIT = 5'h0A;
    localparam logic [15:0] LEN_MAX = 16'h05DC;
    localparam logic [3:0] PRE_NIB = 4'h5;
    localparam logic [3:0] SFD_HI = 4'hD;
    // Special code-groups
    localparam logic [4:0] CG_I = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    // Values after reset, and the CRC polynomial
    localparam logic [9:0] SCR_SEED = 10'h3FF;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    typedef enum logic [3:0] {
        M_IDLE = 4'h0, M_GAP1 = 4'h1, M_GAP2 = 4'h3, M_PRE = 4'h2, M_DATA = 4'h6,
        M_PAD = 4'h7, M_FCS = 4'h5, M_JAM = 4'h4, M_BOFF = 4'hC
    } mac_state_t;
    typedef enum logic [1:0] {P_IDLE = 2'h0, P_K = 2'h1, P_DATA = 2'h3, P_R = 2'h2} pcs_state_t;
    typedef enum logic [2:0] {
        X_IDLE = 3'h0, X_K = 3'h1, X_DATA = 3'h3, X_T = 3'h2, X_DROP = 3'h6
    } rx_state_t;

    // Reflected CRC-32 over one byte, LSB first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [4:0] enc4b5b(input logic [3:0] d);
        logic [79:0] tbl;
        // Nibble d sits at bits 5d+4 down to 5d
        tbl = 80'hEF37_ABDA_727B_96AA_D13E;
        return tbl[{d, 2'b00} + {3'b000, d} +: 5];
    endfunction

    // Returns {valid, nibble}
    function automatic logic [4:0] dec5b4b(input logic [4:0] g);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc4b5b(4'(i)) == g) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Mask of k = min(n, 10) low bits
    function automatic logic [9:0] boff_mask(input logic [4:0] n);
        logic [4:0] k;
        k = (n > BOFF_LIMIT) ? BOFF_LIMIT : n;
        return 10'((11'h001 << k) - 11'h001);
    endfunction
endpackage

/* File: rtl/tx_fifo_mem.sv */
// Dual-port transmit FIFO storage with registered read data
`timescale 1ns/10ps
module tx_fifo_mem #(
    parameter int W = 10,
    parameter int AW = 11
) (
    input wire logic clk,
    fifo_mem_if.mem port
);
    logic [W-1:0] store [0:(1<<AW)-1];

    // Read always registered; caller tolerates one cycle of latency
    always_ff @(posedge clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
        port.rdata <= store[port.raddr];
    end
endmodule

/* File: tb/link_partner.sv */
// Link partner: three-level line monitor and source of received code-groups
`timescale 1ns/10ps
module link_partner (
    input wire logic clk,
    input wire logic reset,
    input wire logic mlt3_pos,
    input wire logic mlt3_neg,
    output logic [4:0] rx_group,
    output logic rx_group_valid
);
    int line_errors;
    int line_steps;
    logic [1:0] last;
    logic [1:0] last_peak;
    initial begin
        rx_group = 5'h00;
        rx_group_valid = 1'b0;
        line_errors = 0;
        line_steps = 0;
        last = 2'b00;
        last_peak = 2'b00;
    end
    // Line steps 0,+1,0,-1 in turn; a peak of the same sign twice is a fault
    always @(posedge clk) begin
        if (!reset && {mlt3_pos, mlt3_neg} != last) begin
            line_steps++;
            if (mlt3_pos && mlt3_neg) begin
                line_errors++;
            end else if (last != 2'b00 && {mlt3_pos, mlt3_neg} != 2'b00) begin
                line_errors++;
            end else if (last == 2'b00 && {mlt3_pos, mlt3_neg} == last_peak) begin
                line_errors++;
            end
            if ({mlt3_pos, mlt3_neg} != 2'b00) begin
                last_peak <= {mlt3_pos, mlt3_neg};
            end
        end
        last <= {mlt3_pos, mlt3_neg};
    end
    // One-cycle strobe; afterwards the group lines show no stale value
    task automatic send(input logic [4:0] g);
        @(negedge clk);
        rx_group = g;
        rx_group_valid = 1'b1;
        @(negedge clk);
        rx_group = ~g;
        rx_group_valid = 1'b0;
    endtask
endmodule

/* File: tb/tb_mac_framing_and_tx_pcs.sv */
// Self-checking bench of the MAC framing and transmit coding block
`timescale 1ns/10ps
module tb_mac_framing_and_tx_pcs;
    import mac_pkg::*;
    logic clk, reset, wr_valid, wr_ready, wr_last, wr_no_pad, crs, col, nrzi_convert_enable;
    logic [7:0] wr_data;
    logic [4:0] rx_group;
    logic rx_group_valid, mlt3_pos, mlt3_neg, tx_active, frame_is_type;
    logic [3:0] rx_nibble, nib;
    logic rx_nibble_valid, rx_frame_end, rx_crc_error, rx_frame_discard;
    int num_errors, checks, cycles, n_end, n_err, n_drop, n_nib, act;
    mac_framing_and_tx_pcs #(.FIFO_DEPTH(64)) mac_framing_and_tx_pcs_inst (
        .clk(clk), .reset(reset), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_last(wr_last), .wr_no_pad(wr_no_pad), .crs(crs), .col(col),
        .nrzi_convert_enable(nrzi_convert_enable), .rx_group(rx_group),
        .rx_group_valid(rx_group_valid), .mlt3_pos(mlt3_pos), .mlt3_neg(mlt3_neg),
        .tx_active(tx_active), .frame_is_type(frame_is_type), .rx_nibble(rx_nibble),
        .rx_nibble_valid(rx_nibble_valid), .rx_frame_end(rx_frame_end),
        .rx_crc_error(rx_crc_error), .rx_frame_discard(rx_frame_discard));
    link_partner link_partner_inst (.clk(clk), .reset(reset), .mlt3_pos(mlt3_pos),
        .mlt3_neg(mlt3_neg), .rx_group(rx_group), .rx_group_valid(rx_group_valid));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Pulse counters, so one-cycle strobes are never missed; cycle ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            stop_test();
        end
        if (rx_frame_end === 1'b1) n_end++;
        if (rx_crc_error === 1'b1) n_err++;
        if (rx_frame_discard === 1'b1) n_drop++;
        if (rx_nibble_valid === 1'b1) begin
            n_nib++;
            nib = rx_nibble;
        end
        if (tx_active === 1'b1) act++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait for a level on tx_active; n reaches lim on a hang
    task automatic wait_act(input logic lvl, input int lim, output int n);
        n = 0;
        while (tx_active !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Header only: addresses, then length/type high and low byte
    task automatic wr_frame(input logic [15:0] lt, input logic no_pad);
        for (int i = 0; i < 14; i++) begin
            @(negedge clk);
            wr_valid = 1'b1;
            wr_data = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : 8'(8'h10 + i);
            wr_last = (i == 13);
            wr_no_pad = no_pad;
            while (wr_ready !== 1'b1) @(negedge clk);
        end
        @(negedge clk);
        wr_valid = 1'b0;
        wr_last = 1'b0;
    endtask
    task automatic t_idle();
        int s;
        for (int e = 1; e >= 0; e--) begin
            nrzi_convert_enable = 1'(e);
            repeat (10) @(negedge clk);
            s = link_partner_inst.line_steps;
            repeat (200) @(negedge clk);
            check(link_partner_inst.line_steps > s, 1);
        end
        nrzi_convert_enable = 1'b1;
    endtask
    task automatic t_rx(input int kind);
        n_end = 0;
        n_err = 0;
        n_drop = 0;
        n_nib = 0;
        if (kind == 2) link_partner_inst.send(5'h1E);
        link_partner_inst.send(CG_I);
        link_partner_inst.send(CG_J);
        link_partner_inst.send(CG_K);
        link_partner_inst.send(5'h1E);
        link_partner_inst.send(5'h16);
        link_partner_inst.send(kind == 1 ? CG_I : CG_T);
        if (kind != 1) link_partner_inst.send(CG_R);
        repeat (3) @(negedge clk);
        check(n_drop, kind == 2);
        check(n_err, kind == 1);
        check(n_end, kind != 1);
        check(nib, 4'hA);
    endtask
    task automatic t_len();
        int n, a1;
        act = 0;
        wr_frame(16'h05DC, 1'b0);
        wait_act(1'b1, 200, n);
        wait_act(1'b0, 2000, n);
        check(frame_is_type, 1'b0);
        a1 = act;
        act = 0;
        wr_frame(16'h05DD, 1'b1);
        wait_act(1'b1, 200, n);
        wait_act(1'b0, 2000, n);
        check(frame_is_type, 1'b1);
        check(a1 - act, (60 - 14) * 2 * 5);
    endtask
    task automatic t_defer();
        int n;
        crs = 1'b1;
        wr_frame(16'h0800, 1'b0);
        repeat (200) @(negedge clk);
        check(tx_active, 1'b0);
        crs = 1'b0;
        repeat (32) @(negedge clk);
        check(tx_active, 1'b0);
        crs = 1'b1;
        wait_act(1'b1, 40, n);
        check(n < 40, 1);
        crs = 1'b0;
        wait_act(1'b0, 2000, n);
    endtask
    task automatic t_col();
        int n;
        wr_frame(16'h0800, 1'b0);
        wait_act(1'b1, 100, n);
        repeat (20) @(negedge clk);
        col = 1'b1;
        repeat (3) @(negedge clk);
        col = 1'b0;
        wait_act(1'b0, 80, n);
        check(n < 80, 1);
        wait_act(1'b1, 500, n);
        check(n < 500, 1);
        wait_act(1'b0, 2000, n);
        check(n < 2000, 1);
    endtask
    initial begin
        {reset, wr_valid, wr_last, wr_no_pad, crs, col} = 6'h20;
        {wr_data, nrzi_convert_enable} = 9'h001;
        {num_errors, checks, cycles, act} = 0;
        repeat (5) @(negedge clk);
        check({wr_ready, tx_active, mlt3_pos, mlt3_neg}, 4'h8);
        reset = 1'b0;
        t_idle();
        for (int k = 0; k < 3; k++) t_rx(k);
        t_len();
        t_defer();
        t_col();
        check(link_partner_inst.line_errors, 0);
        stop_test();
    end
endmodule
